// ---- rtl/ccm_pkg.sv ----
// package: register map, field positions and types for the capture/compare mode control
package ccm_pkg;
    localparam int NUM_MODULES = 6;
    localparam logic [7:0] ADDR_MODULE0_MODE = 8'hda;
    localparam logic [7:0] ADDR_MODULE1_MODE = 8'hdb;
    localparam logic [7:0] ADDR_MODULE2_MODE = 8'hdc;
    localparam logic [7:0] ADDR_MODULE3_MODE = 8'hdd;
    localparam logic [7:0] ADDR_MODULE4_MODE = 8'hde;
    localparam logic [7:0] ADDR_MODULE5_MODE = 8'hce;
    localparam logic [7:0] MODE_RESET = 8'h00;
    // field positions inside a module mode register
    localparam int BIT_WIDE_PWM_SELECT = 7;
    localparam int BIT_COMPARATOR_ENABLE = 6;
    localparam int BIT_RISING_CAPTURE = 5;
    localparam int BIT_FALLING_CAPTURE = 4;
    localparam int BIT_MATCH_ENABLE = 3;
    localparam int BIT_TOGGLE_ENABLE = 2;
    localparam int BIT_PULSE_MODULATION = 1;
    localparam int BIT_MATCH_IRQ_ENABLE = 0;

    typedef enum logic [2:0] {
        CCM_PWM_OFF = 3'h1,
        CCM_PWM_8 = 3'h2,
        CCM_PWM_16 = 3'h4
    } ccm_pwm_mode_t;

    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ccm_sfr_req_t;
endpackage : ccm_pkg

// ---- rtl/ccm_mode_control.sv ----
// capture/compare mode registers, pwm resolution select and overflow irq gate
// Summary of operation
// - wide select matters only with pwm enabled
// - pwm on, wide select 0: 8-bit pwm
// - pwm on, wide select 1: 16-bit pwm
// - six independent mode registers at documented addresses
`timescale 1ns/1ns
`default_nettype none
// strobes are sampled on the rising edge; read data and hit answer one
// cycle later and stand for that cycle only
// mode bytes reach module_mode_out and pwm_mode_out one edge after the
// write edge: register first, then the exported copy
// limitation: the watchdog write lock is not modelled here, so every
// mapped write lands
// enable and flag come from registers on this same clock, hence no
// synchroniser on them

module ccm_mode_control (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // special function register bus
    input wire ccm_pkg::ccm_sfr_req_t sfr_req_in,
    output logic [7:0] sfr_rdata_out,
    output logic sfr_hit_out,
    // array mode control and counter state
    input wire logic overflow_irq_enable_in,
    input wire logic counter_overflow_flag_in,
    // per-module decoded mode
    output logic [ccm_pkg::NUM_MODULES*8-1:0] module_mode_out,
    output logic [ccm_pkg::NUM_MODULES*3-1:0] pwm_mode_out,
    output logic overflow_irq_out
);
    // six independent entries sharing one reset value
    logic [7:0] mode_reg [ccm_pkg::NUM_MODULES];
    logic [7:0] next_mode_reg [ccm_pkg::NUM_MODULES];

    // request fields
    logic req_write;
    logic req_read;
    logic [7:0] req_addr;
    logic [7:0] req_wdata;

    // address decode results and per-module strobes
    logic [ccm_pkg::NUM_MODULES-1:0] sel;
    logic [ccm_pkg::NUM_MODULES-1:0] wr_sel;
    logic [ccm_pkg::NUM_MODULES-1:0] rd_sel;
    logic [7:0] sel_mode;

    // mode fields that steer the pwm resolution
    logic [ccm_pkg::NUM_MODULES-1:0] wide_pwm_select;
    logic [ccm_pkg::NUM_MODULES-1:0] pulse_modulation_enable;

    // next values of the registered outputs
    ccm_pkg::ccm_pwm_mode_t next_pwm_mode [ccm_pkg::NUM_MODULES];
    logic [ccm_pkg::NUM_MODULES*8-1:0] next_module_mode;
    logic [ccm_pkg::NUM_MODULES*3-1:0] next_pwm_mode_flat;
    logic [7:0] next_rdata;
    logic next_hit;
    logic next_irq;

    assign req_write = sfr_req_in.write;
    assign req_read = sfr_req_in.read;
    assign req_addr = sfr_req_in.addr;
    assign req_wdata = sfr_req_in.wdata;

    // address decode, one select per module register
    always_comb begin
        sel = '0;
        if (req_addr == ccm_pkg::ADDR_MODULE0_MODE) begin
            sel[0] = 1'b1;
        end else if (req_addr == ccm_pkg::ADDR_MODULE1_MODE) begin
            sel[1] = 1'b1;
        end else if (req_addr == ccm_pkg::ADDR_MODULE2_MODE) begin
            sel[2] = 1'b1;
        end else if (req_addr == ccm_pkg::ADDR_MODULE3_MODE) begin
            sel[3] = 1'b1;
        end else if (req_addr == ccm_pkg::ADDR_MODULE4_MODE) begin
            sel[4] = 1'b1;
        end else if (req_addr == ccm_pkg::ADDR_MODULE5_MODE) begin
            sel[5] = 1'b1;
        end
    end

    assign wr_sel = sel & {ccm_pkg::NUM_MODULES{req_write}};
    assign rd_sel = sel & {ccm_pkg::NUM_MODULES{req_read}};

    // read mux; unmapped addresses fall through to zero
    always_comb begin
        sel_mode = 8'h00;
        if (sel[0]) begin
            sel_mode = mode_reg[0];
        end else if (sel[1]) begin
            sel_mode = mode_reg[1];
        end else if (sel[2]) begin
            sel_mode = mode_reg[2];
        end else if (sel[3]) begin
            sel_mode = mode_reg[3];
        end else if (sel[4]) begin
            sel_mode = mode_reg[4];
        end else if (sel[5]) begin
            sel_mode = mode_reg[5];
        end
    end

    // write path: an entry changes only through its own strobe
    always_comb begin
        for (int i = 0; i < ccm_pkg::NUM_MODULES; i++) begin
            next_mode_reg[i] = mode_reg[i];
            if (wr_sel[i]) begin
                next_mode_reg[i] = req_wdata;
            end
        end
    end

    // fields read back from the stored bytes
    always_comb begin
        for (int i = 0; i < ccm_pkg::NUM_MODULES; i++) begin
            wide_pwm_select[i] = mode_reg[i][ccm_pkg::BIT_WIDE_PWM_SELECT];
            pulse_modulation_enable[i] = mode_reg[i][ccm_pkg::BIT_PULSE_MODULATION];
        end
    end

    // resolution bit is a don't-care while pwm is off
    always_comb begin
        for (int i = 0; i < ccm_pkg::NUM_MODULES; i++) begin
            case ({pulse_modulation_enable[i], wide_pwm_select[i]})
                2'b11: begin
                    next_pwm_mode[i] = ccm_pkg::CCM_PWM_16;
                end
                2'b10: begin
                    next_pwm_mode[i] = ccm_pkg::CCM_PWM_8;
                end
                default: begin
                    next_pwm_mode[i] = ccm_pkg::CCM_PWM_OFF;
                end
            endcase
        end
    end

    // per-module values onto the output buses
    always_comb begin
        next_module_mode = '0;
        next_pwm_mode_flat = '0;
        for (int i = 0; i < ccm_pkg::NUM_MODULES; i++) begin
            next_module_mode[i*8 +: 8] = mode_reg[i];
            next_pwm_mode_flat[i*3 +: 3] = next_pwm_mode[i];
        end
    end

    // a read in the same cycle as a write returns the old byte
    always_comb begin
        next_rdata = 8'h00;
        next_hit = 1'b0;
        if (|rd_sel) begin
            next_rdata = sel_mode;
        end
        if ((|wr_sel) || (|rd_sel)) begin
            next_hit = 1'b1;
        end
    end

    // request is a plain mask of the flag
    assign next_irq = overflow_irq_enable_in && counter_overflow_flag_in;

    // mode register storage
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < ccm_pkg::NUM_MODULES; i++) begin
                mode_reg[i] <= ccm_pkg::MODE_RESET;
            end
        end else begin
            for (int i = 0; i < ccm_pkg::NUM_MODULES; i++) begin
                mode_reg[i] <= next_mode_reg[i];
            end
        end
    end

    // exported mode bytes, one cycle behind the registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            module_mode_out <= {ccm_pkg::NUM_MODULES{ccm_pkg::MODE_RESET}};
        end else begin
            module_mode_out <= next_module_mode;
        end
    end

    // exported pwm resolution, one-hot per module
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pwm_mode_out <= {ccm_pkg::NUM_MODULES{ccm_pkg::CCM_PWM_OFF}};
        end else begin
            pwm_mode_out <= next_pwm_mode_flat;
        end
    end

    // read data stands for one cycle only
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sfr_rdata_out <= 8'h00;
        end else begin
            sfr_rdata_out <= next_rdata;
        end
    end

    // hit pulse for any access to a mapped entry
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sfr_hit_out <= 1'b0;
        end else begin
            sfr_hit_out <= next_hit;
        end
    end

    // overflow request
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            overflow_irq_out <= 1'b0;
        end else begin
            overflow_irq_out <= next_irq;
        end
    end
endmodule : ccm_mode_control
`default_nettype wire

// ---- verif/ccm_mode_control_asserts.sv ----
// checker: mode register, pwm select and overflow irq properties
`timescale 1ns/1ns
`default_nettype none
module ccm_asserts (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire ccm_pkg::ccm_sfr_req_t sfr_req_in,
    input wire logic sfr_hit_out,
    input wire logic overflow_irq_enable_in,
    input wire logic counter_overflow_flag_in,
    input wire logic [47:0] module_mode_out,
    input wire logic [17:0] pwm_mode_out,
    input wire logic overflow_irq_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_wr5;
        sfr_req_in.write && sfr_req_in.addr == 8'hce;
    endsequence
    sequence s_lands5;
        sfr_hit_out ##1 module_mode_out[47:40] == $past(sfr_req_in.wdata, 2);
    endsequence
    AST_MOD5: assert property (s_wr5 |=> s_lands5) else $error("module 5 write lost");
    sequence s_off_map;
        (sfr_req_in.read || sfr_req_in.write) && sfr_req_in.addr != 8'hce
            && (sfr_req_in.addr < 8'hda || sfr_req_in.addr > 8'hde);
    endsequence
    AST_OFF_MAP: assert property (s_off_map |=> !sfr_hit_out) else $error("unmapped hit");
    AST_PWM_OFF: assert property (!module_mode_out[1] |-> pwm_mode_out[2:0] == 3'h1)
        else $error("pwm on while disabled");
    AST_PWM8: assert property (module_mode_out[1] && !module_mode_out[7] |->
        pwm_mode_out[2:0] == 3'h2) else $error("8-bit pwm missing");
    AST_PWM16: assert property (module_mode_out[1] && module_mode_out[7] |->
        pwm_mode_out[2:0] == 3'h4) else $error("16-bit pwm missing");
    AST_IRQ_ON: assert property (overflow_irq_enable_in && counter_overflow_flag_in
        |=> overflow_irq_out) else $error("irq missing");
    AST_IRQ_MASK: assert property (!overflow_irq_enable_in |=> !overflow_irq_out)
        else $error("irq not masked");
endmodule : ccm_asserts
bind ccm_mode_control ccm_asserts ccm_asserts_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .sfr_req_in(sfr_req_in), .sfr_hit_out(sfr_hit_out), .overflow_irq_out(overflow_irq_out),
    .overflow_irq_enable_in(overflow_irq_enable_in), .module_mode_out(module_mode_out),
    .counter_overflow_flag_in(counter_overflow_flag_in), .pwm_mode_out(pwm_mode_out));
`default_nettype wire

// ---- verif/test_capture_compare_mode_control.sv ----
// testbench: mode registers, pwm select and overflow irq
`timescale 1ns/1ns
`default_nettype none
module test_capture_compare_mode_control;
    logic clk_in = 0, rst_n_in = 0, en = 0, fl = 0, hit, irq;
    ccm_pkg::ccm_sfr_req_t req = '0;
    logic [7:0] rd;
    logic [47:0] mm;
    logic [17:0] pm;
    int n_mismatch = 0, cmp_count = 0, cyc = 0;
    ccm_mode_control ccm_mode_control_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .sfr_req_in(req),
        .sfr_rdata_out(rd), .sfr_hit_out(hit), .overflow_irq_enable_in(en), .pwm_mode_out(pm),
        .counter_overflow_flag_in(fl), .module_mode_out(mm), .overflow_irq_out(irq));
    initial forever #5 clk_in = ~clk_in;
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    // ceiling well above the ~40 cycles the tests take
    always @(posedge clk_in) if (++cyc > 300) begin n_mismatch++; report_and_stop(); end
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp) begin n_mismatch++; $display("ERROR %0t got %h want %h", $time, seen, exp); end
    endtask : chk
    // request held one edge, read back just after it
    task automatic step(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        req = '{w, r, a, d};
        @(posedge clk_in) #1;
    endtask : step
    function automatic logic [7:0] adr(input int i);
        return i == 5 ? 8'hce : 8'hda + i[7:0];
    endfunction : adr
    task automatic t_regs();
        for (int i = 0; i < 6; i++) begin step(0, 1, adr(i), 0); chk({hit, rd}, 9'h100); end
        for (int i = 0; i < 7; i++) step(1, 0, i < 6 ? adr(i) : 8'hd0, 8'h10 + i[7:0]);
        chk(mm, 48'h151413121110);
        chk(pm, {3'h1, 3'h1, 3'h2, 3'h2, 3'h1, 3'h1});
        for (int i = 0; i < 6; i++) begin
            step(0, 1, adr(i), 0);
            chk({hit, rd}, {1'b1, 8'h10 + i[7:0]});
        end
        step(0, 1, 8'hd0, 0);
        chk({hit, rd}, 0);
        step(1, 1, 8'hdb, 8'h5a);
        chk({hit, rd}, 9'h111);
        step(0, 1, 8'hdb, 0);
        chk(rd, 8'h5a);
        $display("register map test done");
    endtask : t_regs
    task automatic t_pwm();
        logic [7:0] v[4] = '{8'h80, 8'h02, 8'h82, 8'h00};
        logic [2:0] e[4] = '{3'h1, 3'h2, 3'h4, 3'h1};
        for (int i = 0; i < 4; i++) begin
            step(1, 0, 8'hda, v[i]);
            step(0, 0, 0, 0);
            chk(pm[2:0], e[i]);
        end
        $display("pwm select test done");
    endtask : t_pwm
    task automatic t_irq();
        for (int i = 0; i < 4; i++) begin
            {en, fl} = i[1:0];
            @(posedge clk_in) #1;
            chk(irq, en & fl);
        end
        $display("overflow irq test done");
    endtask : t_irq
    // mid-run reset: outputs clear at once, entries 5 and 1 read back as reset value
    task automatic t_reset();
        en = 1'b0;
        fl = 1'b0;
        rst_n_in = 1'b0;
        #1;
        chk({hit, rd, irq}, 0);
        chk(mm, 0);
        chk(pm, {6{3'h1}});
        @(posedge clk_in) #1;
        rst_n_in = 1'b1;
        step(0, 1, 8'hce, 0);
        chk({hit, rd}, 9'h100);
        step(0, 1, 8'hdb, 0);
        chk({hit, rd}, 9'h100);
        $display("mid-run reset test done");
    endtask : t_reset
    initial begin
        repeat (4) @(posedge clk_in);
        #1 rst_n_in = 1;
        t_regs();
        t_pwm();
        t_irq();
        t_reset();
        report_and_stop();
    end
endmodule : test_capture_compare_mode_control
`default_nettype wire
